// ===== pkg/irq_ctrl_map.svh
// Register indices, field widths and reset values of the interrupt controller
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_PRIO_LSB_LO   16'hfc00
`define IDX_PRIO_LSB_HI   16'hfc01
`define IDX_PRIO_MSB_LO   16'hfc02
`define IDX_PRIO_MSB_HI   16'hfc03
`define IDX_PEND_LO       16'hfc04
`define IDX_PEND_HI       16'hfc05
`define IDX_LAST_VECTOR   16'hfc06
`define IDX_DEPTH_CNT     16'hfc07
`define IDX_DEPTH_INC     16'hfc08
`define IDX_DEPTH_DEC     16'hfc09

// ==========================================================
// Field layout
`define SRC_COUNT         28
`define SRC_LO_COUNT      16
`define SRC_HI_COUNT      12
`define VEC_W             5
`define DEPTH_W           3
`define DEPTH_MAX         3'h7

// ==========================================================
// Reset values
`define RST_PRIO          28'h000_0000
`define RST_PEND          28'h000_0000
`define RST_VECTOR        5'h00
`define RST_DEPTH         3'h0

`endif

// ===== pkg/irq_ctrl_pkg.sv
// Types shared by the interrupt controller modules
package irq_ctrl_pkg;
  typedef logic [1:0]  prio_t;
  typedef logic [4:0]  vector_t;
  typedef logic [2:0]  depth_t;
  typedef logic [27:0] src_vec_t;
endpackage

// ===== pkg/prio_pick_if.sv
// Carrier between register block and priority picker
`timescale 1ns/1ps
interface prio_pick_if;
  irq_ctrl_pkg::src_vec_t cand;
  irq_ctrl_pkg::src_vec_t lvl_lsb;
  irq_ctrl_pkg::src_vec_t lvl_msb;
  logic                   found;
  irq_ctrl_pkg::vector_t  vec;
  irq_ctrl_pkg::prio_t    level;

  modport req  (output cand, output lvl_lsb, output lvl_msb,
                input found, input vec, input level);
  modport pick (input cand, input lvl_lsb, input lvl_msb,
                output found, output vec, output level);
endinterface

// ===== hdl/prio_picker.sv
// Priority picker: highest level wins, highest vector breaks ties
`timescale 1ns/1ps
`include "irq_ctrl_map.svh"
module prio_picker (
  // Candidates and result
  prio_pick_if.pick pp
);

  // ==========================================================
  // Level decode of one source
  function automatic irq_ctrl_pkg::prio_t lvl_of(input logic m,
                                                 input logic l);
    lvl_of = {m, l};
  endfunction

  // ==========================================================
  // Scan upward; ties keep the later, higher vector
  irq_ctrl_pkg::prio_t   best_lvl;
  irq_ctrl_pkg::vector_t best_vec;
  logic                  best_hit;
  irq_ctrl_pkg::prio_t   cur;

  always_comb begin
    best_lvl = 2'h0;
    best_vec = `RST_VECTOR;
    best_hit = 1'b0;
    cur      = 2'h0;
    for (int i = 0; i < `SRC_COUNT; i++) begin
      cur = lvl_of(pp.lvl_msb[i], pp.lvl_lsb[i]);
      // Masked sources carry level zero and never win
      if (pp.cand[i] && cur != 2'h0 && cur >= best_lvl) begin
        best_lvl = cur;
        best_vec = 5'(i);
        best_hit = 1'b1;
      end
    end
  end

  // Result to the register block
  assign pp.found = best_hit;
  assign pp.vec   = best_vec;
  assign pp.level = best_lvl;

endmodule

// ===== hdl/prioritised_irq_controller.sv
// APB interrupt controller with three priority levels and nesting count
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "irq_ctrl_map.svh"
module prioritised_irq_controller #(
  parameter int ADDR_W = 18
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Peripheral requests, same clock, high for one cycle per event
  input  wire logic [27:0]       irq_src,
  // Core request
  output logic                   irq_req,
  output logic      [4:0]        irq_vec
);

  // ==========================================================
  // Address decode
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [15:0]       idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  wire logic sel_lsb_lo = hit(paddr, `IDX_PRIO_LSB_LO);
  wire logic sel_lsb_hi = hit(paddr, `IDX_PRIO_LSB_HI);
  wire logic sel_msb_lo = hit(paddr, `IDX_PRIO_MSB_LO);
  wire logic sel_msb_hi = hit(paddr, `IDX_PRIO_MSB_HI);
  wire logic sel_pnd_lo = hit(paddr, `IDX_PEND_LO);
  wire logic sel_pnd_hi = hit(paddr, `IDX_PEND_HI);
  wire logic sel_vec    = hit(paddr, `IDX_LAST_VECTOR);
  wire logic sel_cnt    = hit(paddr, `IDX_DEPTH_CNT);
  wire logic sel_inc    = hit(paddr, `IDX_DEPTH_INC);
  wire logic sel_dec    = hit(paddr, `IDX_DEPTH_DEC);
  wire logic sel_any    = sel_lsb_lo | sel_lsb_hi | sel_msb_lo |
                          sel_msb_hi | sel_pnd_lo | sel_pnd_hi |
                          sel_vec | sel_cnt | sel_inc | sel_dec;

  // ==========================================================
  // Bus phases
  wire logic setup_ph = psel & ~penable;
  wire logic access   = psel & penable;
  wire logic wr_acc   = access & pwrite;

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~sel_any;

  // Write strobes per register
  wire logic wr_lsb_lo = wr_acc & sel_lsb_lo;
  wire logic wr_lsb_hi = wr_acc & sel_lsb_hi;
  wire logic wr_msb_lo = wr_acc & sel_msb_lo;
  wire logic wr_msb_hi = wr_acc & sel_msb_hi;
  wire logic wr_pnd_lo = wr_acc & sel_pnd_lo;
  wire logic wr_pnd_hi = wr_acc & sel_pnd_hi;
  wire logic wr_cnt    = wr_acc & sel_cnt;
  wire logic wr_inc    = wr_acc & sel_inc;
  wire logic wr_dec    = wr_acc & sel_dec;

  // ==========================================================
  // State
  irq_ctrl_pkg::src_vec_t lsb_reg, lsb_next;
  irq_ctrl_pkg::src_vec_t msb_reg, msb_next;
  irq_ctrl_pkg::src_vec_t pend_reg, pend_next;
  irq_ctrl_pkg::vector_t  vec_reg, vec_next;
  irq_ctrl_pkg::depth_t   cnt_reg, cnt_next;
  logic                   req_reg;
  logic [31:0]            rdata_reg, rdata_next;

  // ==========================================================
  // Priority bit registers, low and high source halves
  assign lsb_next = { wr_lsb_hi ? pwdata[11:0] : lsb_reg[27:16],
                      wr_lsb_lo ? pwdata[15:0] : lsb_reg[15:0] };
  assign msb_next = { wr_msb_hi ? pwdata[11:0] : msb_reg[27:16],
                      wr_msb_lo ? pwdata[15:0] : msb_reg[15:0] };

  // ==========================================================
  // Picker hookup: only pending and enabled sources compete
  prio_pick_if pk ();
  wire irq_ctrl_pkg::src_vec_t enabled = lsb_reg | msb_reg;

  assign pk.cand    = pend_reg & enabled;
  assign pk.lvl_lsb = lsb_reg;
  assign pk.lvl_msb = msb_reg;

  prio_picker u_pick (
    .pp (pk.pick)
  );

  // Issue when counter is zero and a candidate exists
  wire logic issue = pk.found & (cnt_reg == `RST_DEPTH);

  // One-hot of the issued source
  wire irq_ctrl_pkg::src_vec_t issue_mask =
    issue ? (28'h1 << pk.vec) : `RST_PEND;

  // ==========================================================
  // Pending flags: W1C clear, auto clear on issue, set wins
  wire irq_ctrl_pkg::src_vec_t clr_mask =
    { wr_pnd_hi ? pwdata[11:0] : 12'h000,
      wr_pnd_lo ? pwdata[15:0] : 16'h0000 };

  assign pend_next = (pend_reg & ~clr_mask & ~issue_mask)
                   | irq_src;

  // ==========================================================
  // Last vector record
  assign vec_next = issue ? pk.vec : vec_reg;

  // ==========================================================
  // Nesting counter: strobes, issue, saturation
  wire irq_ctrl_pkg::depth_t cnt_base = wr_cnt ? pwdata[2:0] : cnt_reg;
  wire logic [3:0] cnt_up  = {1'b0, cnt_base} + {3'h0, issue}
                           + {3'h0, wr_inc};
  wire logic       cnt_dn  = wr_dec & (cnt_base != `RST_DEPTH);
  wire logic [3:0] cnt_sum = cnt_up - {3'h0, cnt_dn};

  assign cnt_next = (cnt_sum > {1'b0, `DEPTH_MAX}) ? `DEPTH_MAX
                                                   : cnt_sum[2:0];

  // ==========================================================
  // Read mux, sampled in the setup phase
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (sel_lsb_lo)
      rdata_next[15:0] = lsb_reg[15:0];
    else if (sel_lsb_hi)
      rdata_next[11:0] = lsb_reg[27:16];
    else if (sel_msb_lo)
      rdata_next[15:0] = msb_reg[15:0];
    else if (sel_msb_hi)
      rdata_next[11:0] = msb_reg[27:16];
    else if (sel_pnd_lo)
      rdata_next[15:0] = pend_reg[15:0];
    else if (sel_pnd_hi)
      rdata_next[11:0] = pend_reg[27:16];
    else if (sel_vec)
      rdata_next[4:0] = vec_reg;
    else if (sel_cnt)
      rdata_next[2:0] = cnt_reg;
  end

  // ==========================================================
  // Register update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsb_reg  <= `RST_PRIO;
      msb_reg  <= `RST_PRIO;
      pend_reg <= `RST_PEND;
      vec_reg  <= `RST_VECTOR;
      cnt_reg  <= `RST_DEPTH;
      req_reg  <= 1'b0;
    end else begin
      lsb_reg  <= lsb_next;
      msb_reg  <= msb_next;
      pend_reg <= pend_next;
      vec_reg  <= vec_next;
      cnt_reg  <= cnt_next;
      req_reg  <= issue;
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rdata_reg <= 32'h0000_0000;
    else if (setup_ph)
      rdata_reg <= rdata_next;
  end

  // Outputs
  assign prdata  = rdata_reg;
  assign irq_req = req_reg;
  assign irq_vec = vec_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pend_set_wins: assert property (
    (|irq_src) |=> ((pend_reg & $past(irq_src)) == $past(irq_src)))
    else $error("source request did not set its pending flag");

  a_w1c_clear_low: assert property (
    (wr_pnd_lo && irq_src == 28'h0 && !issue) |=>
      pend_reg[15:0] == ($past(pend_reg[15:0]) & ~$past(pwdata[15:0])))
    else $error("pending clear did not give old and not written");

  a_req_gated_zero: assert property (
    irq_req |-> $past(cnt_reg) == 3'h0)
    else $error("request forwarded with non-zero counter");

  a_issue_auto_clear: assert property (
    (issue && !irq_src[pk.vec]) |=> !pend_reg[vec_reg])
    else $error("issued source pending flag not cleared");

  a_issue_count_one: assert property (
    (issue && !wr_inc && !wr_cnt) |=> (cnt_reg == 3'h1) && irq_req)
    else $error("issue did not raise counter to one");

  a_issue_inc_two: assert property (
    (issue && wr_inc && !wr_cnt) |=> cnt_reg == 3'h2)
    else $error("issue with increment strobe did not add two");

  a_dec_nonzero: assert property (
    (wr_dec && cnt_reg != 3'h0) |=> cnt_reg == $past(cnt_reg) - 3'h1)
    else $error("decrement strobe did not lower the counter");

  a_dec_at_zero: assert property (
    (wr_dec && cnt_reg == 3'h0 && !issue) |=> cnt_reg == 3'h0)
    else $error("decrement at zero changed the counter");

  a_depth_saturate: assert property (
    (cnt_reg == 3'h7 && wr_inc) |=> cnt_reg == 3'h7)
    else $error("counter wrapped past seven");

  a_masked_no_issue: assert property (
    issue |-> enabled[pk.vec] && pend_reg[pk.vec] && pk.level != 2'h0)
    else $error("masked or idle source was issued");

  a_held_off_quiet: assert property (
    (cnt_reg != 3'h0) [*2] |-> !irq_req)
    else $error("request seen while nesting counter non-zero");

  a_vec_in_range: assert property (
    vec_reg <= 5'h1b)
    else $error("last vector outside the source range");

  a_vec_recorded: assert property (
    issue |=> irq_vec == $past(pk.vec))
    else $error("issued vector not recorded");

  a_req_one_pulse: assert property (
    irq_req |=> !irq_req)
    else $error("core request longer than one cycle");

  a_inc_strobe_one: assert property (
    (wr_inc && !issue && cnt_reg != 3'h7) |=>
      cnt_reg == $past(cnt_reg) + 3'h1)
    else $error("increment strobe did not add one");

  a_masked_keep_pend: assert property (
    (!wr_pnd_lo && !wr_pnd_hi && !wr_lsb_lo && !wr_lsb_hi &&
     !wr_msb_lo && !wr_msb_hi) |=>
      (pend_reg & $past(pend_reg & ~enabled)) ==
        $past(pend_reg & ~enabled))
    else $error("masked pending flag lost without a clear");

  a_read_keeps_pend: assert property (
    (setup_ph && !pwrite && (sel_pnd_lo || sel_pnd_hi) && !issue) |=>
      (pend_reg & $past(pend_reg)) == $past(pend_reg))
    else $error("reading pending flags changed them");

  c_single_issue: cover property (issue ##1 irq_req);
  c_issue_and_inc: cover property (issue && wr_inc);
  c_reenable_issue: cover property (wr_dec ##1 issue);
  c_tie_break: cover property (issue && $countones(pk.cand) > 1);
  c_masked_poll: cover property (|(pend_reg & ~enabled));

endmodule

// ===== bench/core_model.sv
// Behavioural processor core that counts vectored requests
`timescale 1ns/1ps
module core_model (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Request from the controller
  input  wire logic                  irq_req,
  input  wire irq_ctrl_pkg::vector_t irq_vec,
  // Observed requests
  output logic [7:0]                 n_irq,
  output irq_ctrl_pkg::vector_t      seen_vec
);
  // Take the vector on each one-cycle request pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_irq    <= 8'h00;
      seen_vec <= 5'h00;
    end else if (irq_req) begin
      n_irq    <= n_irq + 8'h01;
      seen_vec <= irq_vec;
    end
  end
endmodule

// ===== bench/tb_prioritised_irq_controller.sv
// Self-checking bench for the prioritised interrupt controller
`timescale 1ns/1ps
`include "irq_ctrl_map.svh"
module tb_prioritised_irq_controller;
  // ==========================================================
  // Signals
  localparam logic [31:0] z32  = 32'h0000_0000;
  localparam logic [27:0] nsrc = 28'h000_0000;
  localparam logic [4:0]  order_tbl [4] = '{5'h14, 5'h09, 5'h0c, 5'h03};
  logic                  pclk     = 1'b0;
  logic                  presetn  = 1'b0;
  logic [17:0]           paddr    = 18'h0_0000;
  logic                  psel     = 1'b0;
  logic                  penable  = 1'b0;
  logic                  pwrite   = 1'b0;
  logic [31:0]           pwdata   = 32'h0000_0000;
  logic [27:0]           irq_src  = 28'h000_0000;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  irq_req;
  irq_ctrl_pkg::vector_t irq_vec;
  irq_ctrl_pkg::vector_t seen_vec;
  logic [7:0]            n_irq;
  logic [7:0]            exp_irq  = 8'h00;
  logic [31:0]           rdata;
  logic                  last_err;
  int                    errors   = 0;
  int                    n_checks = 0;
  int                    cycles   = 0;

  // ==========================================================
  // Design and core model
  prioritised_irq_controller i_prioritised_irq_controller (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_src(irq_src), .irq_req(irq_req), .irq_vec(irq_vec));
  core_model i_core_model (
    .pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .irq_vec(irq_vec), .n_irq(n_irq), .seen_vec(seen_vec));

  // ==========================================================
  // Clock and hang guard
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  // ==========================================================
  // Tasks
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; source pulses ride on setup and access cycles
  task automatic xfer(input logic wr, input logic [15:0] idx,
                      input logic [31:0] wd, input logic [27:0] src);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    irq_src <= src;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata    = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    irq_src <= nsrc;
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp,
                       input logic [27:0] src);
    xfer(1'b0, idx, z32, src);
    chk($sformatf("reg %h", idx), exp, rdata);
  endtask

  task automatic core_chk(input logic [4:0] v);
    chk("irq count", {24'h00_0000, exp_irq}, {24'h00_0000, n_irq});
    chk("irq vector", {27'h000_0000, v}, {27'h000_0000, seen_vec});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values of all readable registers
    for (int i = 0; i < 8; i++)
      rdchk(16'hfc00 + 16'(i), z32, nsrc);
    // Field widths of low and high priority registers
    xfer(1'b1, `IDX_PRIO_LSB_LO, 32'hffff_ffff, nsrc);
    xfer(1'b1, `IDX_PRIO_MSB_HI, 32'hffff_ffff, nsrc);
    rdchk(`IDX_PRIO_LSB_LO, 32'h0000_ffff, nsrc);
    rdchk(`IDX_PRIO_MSB_HI, 32'h0000_0fff, nsrc);
    xfer(1'b1, `IDX_PRIO_LSB_LO, z32, nsrc);
    xfer(1'b1, `IDX_PRIO_MSB_HI, z32, nsrc);
    // Masked sources latch and keep pending flags
    xfer(1'b0, `IDX_LAST_VECTOR, z32, 28'h000_00ff);
    rdchk(`IDX_PEND_LO, 32'h0000_00ff, nsrc);
    rdchk(`IDX_PEND_LO, 32'h0000_00ff, nsrc);
    core_chk(5'h00);
    xfer(1'b1, `IDX_PEND_LO, 32'h0000_f00f, nsrc);
    rdchk(`IDX_PEND_LO, 32'h0000_00f0, nsrc);
    xfer(1'b1, `IDX_PEND_LO, 32'h0000_0010, 28'h000_0010);
    rdchk(`IDX_PEND_LO, 32'h0000_00f0, nsrc);
    xfer(1'b1, `IDX_PEND_LO, 32'h0000_ffff, nsrc);
    rdchk(`IDX_PEND_LO, z32, nsrc);
    // Hold off, raise four sources, then release one at a time
    xfer(1'b1, `IDX_DEPTH_INC, 32'h0000_1234, nsrc);
    xfer(1'b1, `IDX_PRIO_LSB_LO, 32'h0000_0208, nsrc);
    xfer(1'b1, `IDX_PRIO_MSB_LO, 32'h0000_1200, nsrc);
    xfer(1'b1, `IDX_PRIO_LSB_HI, 32'h0000_0010, nsrc);
    xfer(1'b1, `IDX_PRIO_MSB_HI, 32'h0000_0010, nsrc);
    rdchk(`IDX_DEPTH_CNT, 32'h0000_0001, 28'h010_1208);
    rdchk(`IDX_PEND_HI, 32'h0000_0010, nsrc);
    core_chk(5'h00);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, `IDX_DEPTH_DEC, z32, nsrc);
      rdchk(`IDX_DEPTH_CNT, 32'h0000_0001, nsrc);
      rdchk(`IDX_LAST_VECTOR, 32'(order_tbl[i]), nsrc);
      exp_irq++;
      core_chk(order_tbl[i]);
    end
    rdchk(`IDX_PEND_LO, z32, nsrc);
    xfer(1'b1, `IDX_LAST_VECTOR, 32'h0000_001f, nsrc);
    rdchk(`IDX_LAST_VECTOR, 32'h0000_0003, nsrc);
    xfer(1'b1, `IDX_DEPTH_DEC, z32, nsrc);
    // Issue in the same cycle as an increment strobe
    xfer(1'b1, `IDX_DEPTH_INC, z32, 28'h010_0000);
    rdchk(`IDX_DEPTH_CNT, 32'h0000_0002, nsrc);
    exp_irq++;
    core_chk(5'h14);
    xfer(1'b1, `IDX_PEND_HI, 32'h0000_0010, nsrc);
    repeat (2) xfer(1'b1, `IDX_DEPTH_DEC, z32, nsrc);
    rdchk(`IDX_DEPTH_CNT, z32, nsrc);
    core_chk(5'h14);
    // Saturation at seven, floor at zero
    repeat (8) xfer(1'b1, `IDX_DEPTH_INC, z32, nsrc);
    rdchk(`IDX_DEPTH_CNT, 32'h0000_0007, nsrc);
    repeat (8) xfer(1'b1, `IDX_DEPTH_DEC, z32, nsrc);
    rdchk(`IDX_DEPTH_CNT, z32, nsrc);
    // Unmapped address answers with an error and zero data
    xfer(1'b0, 16'hfc0a, z32, nsrc);
    chk("pslverr", 32'h0000_0001, {31'h0000_0000, last_err});
    chk("unmapped data", z32, rdata);
    // Mapped address answers without an error
    xfer(1'b0, `IDX_DEPTH_CNT, z32, nsrc);
    chk("pslverr mapped", z32, {31'h0000_0000, last_err});
    stop_test();
  end
endmodule
